// *** rtl/phmcr_pkg.sv ***
// Register map, field layout and timing constants of the phase management registers
package phmcr_pkg;
  localparam logic [7:0] ADDR_POWER_SAVE_PIN_STATUS = 8'h32;
  localparam logic [7:0] ADDR_PHASE_STATUS = 8'h33;
  localparam logic [7:0] ADDR_ZONE_ENABLE = 8'h34;
  localparam logic [7:0] ADDR_ZONE_STATUS = 8'h35;
  localparam logic [7:0] ADDR_ZONE_CONFIG = 8'h36;
  localparam logic [7:0] ADDR_LOAD_LINE = 8'h39;
  localparam logic [7:0] ADDR_SHED_CFG1 = 8'h3a;
  localparam logic [7:0] ADDR_SHED_STS1 = 8'h3b;
  localparam logic [7:0] ADDR_SHED_CFG2 = 8'h3c;
  localparam logic [7:0] ADDR_SHED_STS2 = 8'h3d;
  localparam logic [7:0] ADDR_SHED_CFG3 = 8'h3e;
  localparam logic [7:0] ADDR_SHED_STS3 = 8'h3f;
  localparam logic [7:0] ADDR_SHED_CFG4 = 8'h40;
  localparam logic [7:0] ADDR_SHED_STS4 = 8'h41;
  localparam logic [7:0] ADDR_SHED_HYST = 8'h44;
  localparam logic [7:0] ADDR_SHED_DELAY = 8'h45;
  localparam logic [7:0] ADDR_LATCH_A = 8'h46;
  localparam logic [7:0] ADDR_LATCH_B = 8'h47;
  localparam logic [7:0] ADDR_SENSE_VOLT = 8'h48;
  localparam logic [7:0] ADDR_STAGE_TEMP = 8'h49;
  localparam logic [7:0] ADDR_TEMP_RESP = 8'h4a;
  localparam logic [7:0] ADDR_TSD_CONFIG = 8'h4b;

  localparam logic [1:0] PSI_MID = 2'h0;
  localparam logic [1:0] PSI_LOW = 2'h1;
  localparam logic [1:0] PSI_HIGH = 2'h2;

  localparam logic [4:0] ZONE_ENABLE_RESET = 5'h1f;
  localparam logic [2:0] ZONE_CODE_MAX = 3'h4;
  localparam logic [2:0] ZONE_SECOND_TOP_CODE = 3'h4;
  localparam logic [2:0] ZONE_SECOND_TOP_LEVEL = 3'h3;
  localparam int ZONE_FIRST_MSB = 5;
  localparam int ZONE_FIRST_LSB = 3;
  localparam int ZONE_SECOND_MSB = 2;
  localparam int ZONE_SECOND_LSB = 0;

  localparam logic [1:0] LOAD_LINE_RESET = 2'h3;
  localparam logic [7:0] SHED_DISABLED = 8'hff;
  localparam logic [7:0] SHED_HYST_RESET = 8'h00;
  localparam logic [7:0] SHED_DELAY_RESET = 8'h14;

  localparam int LATCH_FREQ_BIT = 5;
  localparam int LATCH_SOFTSTART_BIT = 3;
  localparam int LATCH_ILIM_BIT = 2;
  localparam int LATCH_ZONE_BIT = 1;
  localparam int LATCH_SHED_BIT = 0;
  localparam logic [7:0] LATCH_MASK = 8'h2f;

  localparam int TSD_ENABLE_BIT = 1;
  localparam int RESP_HICCUP_BIT = 0;

  localparam int CLK_HZ = 40_000_000;
  localparam int SHED_STEP_US = 30;
  localparam int SHED_STEP_CYCLES = CLK_HZ / 1_000_000 * SHED_STEP_US;
endpackage : phmcr_pkg

// *** rtl/phmcr_regs.sv ***
// Phase management configuration and status registers with shedding control
// Functional notes
// R01 - Power-saving pin level reads as 00 mid, 01 low, 10 high.
// R02 - Read-only byte, bit n-1 shows phase n enabled.
// R03 - Five zone-enable bits reset enabled, act while power-saving input is low.
// R04 - At power-on sense zone pins, set zone, record in zone status.
// R05 - Zone fields 5:3 and 2:0; second code 100 gives level 3; 101-111 reserved.
// R06 - Register zone used only while zone bit set in both latches.
// R07 - Load line fraction 00 100%, 01 50%, 10 25%, 11 0%; reset 11.
// R08 - Register shed thresholds used only when threshold bit set; compared to current.
// R09 - Threshold value ff disables that shedding threshold.
// R10 - Pin thresholds captured at power-on; above 2 V disables threshold.
// R11 - Hysteresis in threshold codes applied when dropping phase count.
// R12 - Delay before dropping phase count; reset 14h, 30 us per step.
// R13 - Mode changes only when both latches get same byte; resistor control after cold start.
// R14 - Latch bits 5,3,2,1,0 move frequency, soft-start, limit, zone, shedding to registers.
// R15 - Read-only 8-bit remote-sense voltage, ff is 2 V.
// R16 - Read-only 8-bit power stage temperature, full scale 2 V.
// R17 - Stage temperature fault latches off when bit 0 clear, hiccup when set.
// R18 - Thermal shutdown only when bit 1 set; bit 0 picks latch or hiccup.
// R19 - While latches differ, keep last mode agreed by both.
// R20 - Reserved bits read zero; writes to them have no effect.
`timescale 1ns/1ps
`default_nettype none
module phmcr_regs (
  input wire logic clk, // 40 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register offset from serial port engine
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata, // Read data, valid cycle after reg_rd
  input wire logic [1:0] power_saving_input, // Pin level code, async
  input wire logic [7:0] phase_enabled, // Phase enable state from loop, async
  input wire logic power_on_sense, // Pulse: resistor sensing done, same clock
  input wire logic [2:0] zone_pin_first, // Sensed first zone code
  input wire logic [2:0] zone_pin_second, // Sensed second zone code
  input wire logic [31:0] shed_pin_value, // Four sensed pin thresholds, byte each
  input wire logic [3:0] shed_pin_over_2v, // Sensed pin voltage above 2 V
  input wire logic [7:0] output_current_reading, // Output current code, async
  input wire logic [7:0] sense_voltage_monitor, // Remote-sense voltage code, async
  input wire logic [7:0] stage_temp_monitor, // Stage temperature code, async
  input wire logic stage_temp_fault, // Stage temperature fault, async
  input wire logic thermal_shutdown_fault, // Die over-temperature, async
  output logic [2:0] zone_level_first, // Active first zone level
  output logic [2:0] zone_level_second, // Active second zone level
  output logic [4:0] zone_active_mask, // Zones allowed now
  output logic [1:0] load_line, // Load line fraction code
  output logic switching_frequency_select, // Frequency from register
  output logic softstart_from_reg, // Soft-start from register
  output logic per_phase_current_limit, // Current limit from register
  output logic [2:0] shed_count, // Thresholds exceeded, held through hysteresis and delay
  output logic thermal_shutdown_enable, // Thermal shutdown armed
  output logic fault_latched_off, // Latched off until reset
  output logic fault_hiccup // One-cycle hiccup request
);

  logic [1:0] psi_meta, psi_sync;
  logic [7:0] phase_meta, phase_sync;
  logic [7:0] iout_meta, iout_sync;
  logic [7:0] volt_meta, volt_sync;
  logic [7:0] temp_meta, temp_sync;
  logic [1:0] flt_meta, flt_sync, flt_prev;

  logic [4:0] zone_enable;
  logic [5:0] zone_status;
  logic [5:0] zone_config;
  logic [1:0] load_line_reg;
  logic [7:0] shed_cfg [4];
  logic [7:0] shed_sts [4];
  logic [7:0] shed_hyst;
  logic [7:0] shed_delay;
  logic [7:0] latch_a, latch_b, mode;
  logic temp_resp;
  logic [1:0] tsd_cfg;

  // Async pins and analog-domain values reach two flops before any logic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      psi_meta <= 2'h0;
      psi_sync <= 2'h0;
      phase_meta <= 8'h00;
      phase_sync <= 8'h00;
      iout_meta <= 8'h00;
      iout_sync <= 8'h00;
      volt_meta <= 8'h00;
      volt_sync <= 8'h00;
      temp_meta <= 8'h00;
      temp_sync <= 8'h00;
      flt_meta <= 2'h0;
      flt_sync <= 2'h0;
    end else begin
      psi_meta <= power_saving_input;
      psi_sync <= psi_meta;
      phase_meta <= phase_enabled;
      phase_sync <= phase_meta;
      iout_meta <= output_current_reading;
      iout_sync <= iout_meta;
      volt_meta <= sense_voltage_monitor;
      volt_sync <= volt_meta;
      temp_meta <= stage_temp_monitor;
      temp_sync <= temp_meta;
      flt_meta <= {thermal_shutdown_fault, stage_temp_fault};
      flt_sync <= flt_meta;
    end
  end

  function automatic logic zone_code_ok(input logic [2:0] code);
    zone_code_ok = (code <= phmcr_pkg::ZONE_CODE_MAX);
  endfunction : zone_code_ok

  // Power-on capture of resistor settings
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zone_status <= 6'h00;
      for (int i = 0; i < 4; i++) begin
        shed_sts[i] <= phmcr_pkg::SHED_DISABLED;
      end
    end else if (power_on_sense) begin
      zone_status <= {zone_pin_first, zone_pin_second}; // [R04]
      for (int i = 0; i < 4; i++) begin
        shed_sts[i] <= shed_pin_over_2v[i] ? phmcr_pkg::SHED_DISABLED
                                           : shed_pin_value[8*i +: 8]; // [R10]
      end
    end
  end

  // Writable configuration
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zone_enable <= phmcr_pkg::ZONE_ENABLE_RESET; // [R03]
      zone_config <= 6'h00;
      load_line_reg <= phmcr_pkg::LOAD_LINE_RESET; // [R07]
      for (int i = 0; i < 4; i++) begin
        shed_cfg[i] <= phmcr_pkg::SHED_DISABLED;
      end
      shed_hyst <= phmcr_pkg::SHED_HYST_RESET;
      shed_delay <= phmcr_pkg::SHED_DELAY_RESET; // [R12]
      temp_resp <= 1'b0;
      tsd_cfg <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        phmcr_pkg::ADDR_ZONE_ENABLE: zone_enable <= reg_wdata[4:0]; // [R20]
        phmcr_pkg::ADDR_ZONE_CONFIG: begin
          // Reserved codes are refused per field, old value kept
          if (zone_code_ok(reg_wdata[phmcr_pkg::ZONE_FIRST_MSB:phmcr_pkg::ZONE_FIRST_LSB])) begin
            zone_config[5:3] <= reg_wdata[5:3]; // [R05]
          end
          if (zone_code_ok(reg_wdata[2:0])) begin
            zone_config[2:0] <= reg_wdata[2:0]; // [R05]
          end
        end
        phmcr_pkg::ADDR_LOAD_LINE: load_line_reg <= reg_wdata[1:0];
        phmcr_pkg::ADDR_SHED_CFG1: shed_cfg[0] <= reg_wdata;
        phmcr_pkg::ADDR_SHED_CFG2: shed_cfg[1] <= reg_wdata;
        phmcr_pkg::ADDR_SHED_CFG3: shed_cfg[2] <= reg_wdata;
        phmcr_pkg::ADDR_SHED_CFG4: shed_cfg[3] <= reg_wdata;
        phmcr_pkg::ADDR_SHED_HYST: shed_hyst <= reg_wdata;
        phmcr_pkg::ADDR_SHED_DELAY: shed_delay <= reg_wdata;
        phmcr_pkg::ADDR_TEMP_RESP: temp_resp <= reg_wdata[phmcr_pkg::RESP_HICCUP_BIT];
        phmcr_pkg::ADDR_TSD_CONFIG: tsd_cfg <= reg_wdata[1:0]; // [R20]
        default: ;
      endcase
    end
  end

  // Latch pair: mode moves only when a write makes both bytes equal
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_a <= 8'h00;
      latch_b <= 8'h00;
      mode <= 8'h00; // [R13]
    end else if (reg_wr) begin
      if (reg_addr == phmcr_pkg::ADDR_LATCH_A) begin
        latch_a <= reg_wdata & phmcr_pkg::LATCH_MASK; // [R20]
        if ((reg_wdata & phmcr_pkg::LATCH_MASK) == latch_b) begin
          mode <= latch_b; // [R13]
        end
      end else if (reg_addr == phmcr_pkg::ADDR_LATCH_B) begin
        latch_b <= reg_wdata & phmcr_pkg::LATCH_MASK;
        if ((reg_wdata & phmcr_pkg::LATCH_MASK) == latch_a) begin
          mode <= latch_a; // [R13] [R19]
        end
      end
    end
  end

  assign switching_frequency_select = mode[phmcr_pkg::LATCH_FREQ_BIT]; // [R14]
  assign softstart_from_reg = mode[phmcr_pkg::LATCH_SOFTSTART_BIT]; // [R14]
  assign per_phase_current_limit = mode[phmcr_pkg::LATCH_ILIM_BIT]; // [R14]

  logic [5:0] zone_sel;
  logic [2:0] zone_second_code;
  assign zone_sel = mode[phmcr_pkg::LATCH_ZONE_BIT] ? zone_config : zone_status; // [R06]
  assign zone_second_code = zone_sel[phmcr_pkg::ZONE_SECOND_MSB:phmcr_pkg::ZONE_SECOND_LSB];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zone_level_first <= 3'h0;
      zone_level_second <= 3'h0;
      zone_active_mask <= phmcr_pkg::ZONE_ENABLE_RESET;
      load_line <= phmcr_pkg::LOAD_LINE_RESET;
      thermal_shutdown_enable <= 1'b0;
    end else begin
      zone_level_first <= zone_sel[5:3];
      zone_level_second <= (zone_second_code == phmcr_pkg::ZONE_SECOND_TOP_CODE) ?
                           phmcr_pkg::ZONE_SECOND_TOP_LEVEL : zone_second_code; // [R05]
      zone_active_mask <= (psi_sync == phmcr_pkg::PSI_LOW) ? zone_enable
                          : phmcr_pkg::ZONE_ENABLE_RESET; // [R03]
      load_line <= load_line_reg; // [R07]
      thermal_shutdown_enable <= tsd_cfg[phmcr_pkg::TSD_ENABLE_BIT]; // [R18]
    end
  end

  // Phase shedding: rise at once, fall only after hysteresis and delay
  logic [7:0] thr [4];
  logic [2:0] up_count, down_count;
  always_comb begin
    up_count = 3'h0;
    down_count = 3'h0;
    for (int i = 0; i < 4; i++) begin
      thr[i] = mode[phmcr_pkg::LATCH_SHED_BIT] ? shed_cfg[i] : shed_sts[i]; // [R08]
      if (thr[i] != phmcr_pkg::SHED_DISABLED) begin // [R09]
        if (iout_sync >= thr[i]) begin
          up_count = up_count + 3'h1;
        end
        // Stays counted until current falls below threshold minus hysteresis
        if ({1'b0, iout_sync} + {1'b0, shed_hyst} >= {1'b0, thr[i]}) begin // [R11]
          down_count = down_count + 3'h1;
        end
      end
    end
  end

  logic [10:0] step_cnt;
  logic step_tick;
  logic [7:0] delay_cnt;
  assign step_tick = (step_cnt == 11'(phmcr_pkg::SHED_STEP_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_cnt <= 11'h000;
    end else if (step_tick || down_count >= shed_count) begin
      step_cnt <= 11'h000;
    end else begin
      step_cnt <= step_cnt + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shed_count <= 3'h0;
      delay_cnt <= 8'h00;
    end else if (up_count > shed_count) begin
      shed_count <= up_count;
      delay_cnt <= 8'h00;
    end else if (down_count >= shed_count) begin
      delay_cnt <= 8'h00;
    end else if (step_tick) begin
      if (delay_cnt + 8'h01 >= shed_delay) begin // [R12]
        shed_count <= down_count;
        delay_cnt <= 8'h00;
      end else begin
        delay_cnt <= delay_cnt + 8'h01;
      end
    end
  end

  // Fault responses on rising fault edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flt_prev <= 2'h0;
      fault_latched_off <= 1'b0;
      fault_hiccup <= 1'b0;
    end else begin
      flt_prev <= flt_sync;
      fault_hiccup <= 1'b0;
      if (flt_sync[0] && !flt_prev[0]) begin
        if (temp_resp) begin
          fault_hiccup <= 1'b1; // [R17]
        end else begin
          fault_latched_off <= 1'b1; // [R17]
        end
      end
      if (flt_sync[1] && !flt_prev[1] && tsd_cfg[phmcr_pkg::TSD_ENABLE_BIT]) begin // [R18]
        if (tsd_cfg[phmcr_pkg::RESP_HICCUP_BIT]) begin
          fault_hiccup <= 1'b1;
        end else begin
          fault_latched_off <= 1'b1;
        end
      end
    end
  end

  // Read path
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        phmcr_pkg::ADDR_POWER_SAVE_PIN_STATUS: reg_rdata <= {6'h00, psi_sync}; // [R01]
        phmcr_pkg::ADDR_PHASE_STATUS: reg_rdata <= phase_sync; // [R02]
        phmcr_pkg::ADDR_ZONE_ENABLE: reg_rdata <= {3'h0, zone_enable};
        phmcr_pkg::ADDR_ZONE_STATUS: reg_rdata <= {2'h0, zone_status}; // [R20]
        phmcr_pkg::ADDR_ZONE_CONFIG: reg_rdata <= {2'h0, zone_config};
        phmcr_pkg::ADDR_LOAD_LINE: reg_rdata <= {6'h00, load_line_reg};
        phmcr_pkg::ADDR_SHED_CFG1: reg_rdata <= shed_cfg[0];
        phmcr_pkg::ADDR_SHED_STS1: reg_rdata <= shed_sts[0];
        phmcr_pkg::ADDR_SHED_CFG2: reg_rdata <= shed_cfg[1];
        phmcr_pkg::ADDR_SHED_STS2: reg_rdata <= shed_sts[1];
        phmcr_pkg::ADDR_SHED_CFG3: reg_rdata <= shed_cfg[2];
        phmcr_pkg::ADDR_SHED_STS3: reg_rdata <= shed_sts[2];
        phmcr_pkg::ADDR_SHED_CFG4: reg_rdata <= shed_cfg[3];
        phmcr_pkg::ADDR_SHED_STS4: reg_rdata <= shed_sts[3];
        phmcr_pkg::ADDR_SHED_HYST: reg_rdata <= shed_hyst;
        phmcr_pkg::ADDR_SHED_DELAY: reg_rdata <= shed_delay;
        phmcr_pkg::ADDR_LATCH_A: reg_rdata <= latch_a;
        phmcr_pkg::ADDR_LATCH_B: reg_rdata <= latch_b;
        phmcr_pkg::ADDR_SENSE_VOLT: reg_rdata <= volt_sync; // [R15]
        phmcr_pkg::ADDR_STAGE_TEMP: reg_rdata <= temp_sync; // [R16]
        phmcr_pkg::ADDR_TEMP_RESP: reg_rdata <= {7'h00, temp_resp};
        phmcr_pkg::ADDR_TSD_CONFIG: reg_rdata <= {6'h00, tsd_cfg};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : phmcr_regs
`default_nettype wire

// *** tb/phmcr_host.sv ***
// Host model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module phmcr_host (
  input wire logic clk, // Port clock
  output logic [7:0] reg_addr, // Offset
  output logic [7:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd // Read strobe
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d; // Idle bus never shows the last value
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : phmcr_host
`default_nettype wire

// *** tb/phmcr_regs_sva.sv ***
// Port-level assertions for the phase management registers
`timescale 1ns/1ps
`default_nettype none
module phmcr_regs_sva (
  input wire logic clk, // Clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [7:0] reg_addr, // Offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic [1:0] power_saving_input, // Pin level code
  input wire logic [2:0] zone_level_first, // First zone level
  input wire logic [2:0] zone_level_second, // Second zone level
  input wire logic [4:0] zone_active_mask, // Allowed zones
  input wire logic [1:0] load_line, // Load line code
  input wire logic switching_frequency_select, // Mode bit 5
  input wire logic softstart_from_reg, // Mode bit 3
  input wire logic per_phase_current_limit, // Mode bit 2
  input wire logic [2:0] shed_count, // Exceeded thresholds
  input wire logic thermal_shutdown_enable, // Shutdown armed
  input wire logic fault_latched_off, // Latched off
  input wire logic fault_hiccup // Hiccup pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] prev_cnt;
  logic [11:0] hold_n;
  logic latch_wr_q;
  // Counts cycles the shed count has stood, saturating to stay small
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_cnt <= 3'h0;
      hold_n <= 12'h000;
      latch_wr_q <= 1'b0;
    end else begin
      prev_cnt <= shed_count;
      hold_n <= (shed_count != prev_cnt) ? 12'h000 : (hold_n < 12'h7d0) ? hold_n + 12'h001 : hold_n;
      latch_wr_q <= reg_wr && (reg_addr == phmcr_pkg::ADDR_LATCH_A || reg_addr == phmcr_pkg::ADDR_LATCH_B);
    end
  end
  sequence s_psi_steady;
    $stable(power_saving_input) [*4];
  endsequence
  sequence s_latched_run;
    fault_latched_off [*8];
  endsequence
  property p_psi_rsvd;
    reg_rd && reg_addr == phmcr_pkg::ADDR_POWER_SAVE_PIN_STATUS |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_psi_rsvd: assert property (p_psi_rsvd) else $error("power_save_pin_status reserved bits set");
  property p_unmapped;
    reg_rd && reg_addr == 8'h50 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mask_idle;
    s_psi_steady ##0 (power_saving_input != phmcr_pkg::PSI_LOW) |-> zone_active_mask == 5'h1f;
  endproperty
  a_mask_idle: assert property (p_mask_idle) else $error("zone mask applied outside low");
  property p_zone_range;
    zone_level_first <= phmcr_pkg::ZONE_CODE_MAX && zone_level_second <= 3'h3;
  endproperty
  a_zone_range: assert property (p_zone_range) else $error("zone level out of range");
  property p_load_wr;
    // Output is one flop behind the register, so two edges after the write
    reg_wr && reg_addr == phmcr_pkg::ADDR_LOAD_LINE |=>
      ##1 load_line == $past(reg_wdata[1:0], 2);
  endproperty
  a_load_wr: assert property (p_load_wr) else $error("load line not updated");
  property p_tsd_wr;
    reg_wr && reg_addr == phmcr_pkg::ADDR_TSD_CONFIG |=>
      ##1 thermal_shutdown_enable == $past(reg_wdata[1], 2);
  endproperty
  a_tsd_wr: assert property (p_tsd_wr) else $error("shutdown enable not updated");
  property p_mode_cause;
    $changed({switching_frequency_select, softstart_from_reg, per_phase_current_limit}) |-> latch_wr_q;
  endproperty
  a_mode_cause: assert property (p_mode_cause) else $error("mode moved without latch write");
  property p_hic_pulse;
    fault_hiccup |=> !fault_hiccup;
  endproperty
  a_hic_pulse: assert property (p_hic_pulse) else $error("hiccup longer than one cycle");
  property p_latch_sticky;
    $rose(fault_latched_off) |=> s_latched_run;
  endproperty
  a_latch_sticky: assert property (p_latch_sticky) else $error("latched off released");
  property p_shed_delay;
    shed_count < prev_cnt |-> hold_n >= 12'h4af;
  endproperty
  a_shed_delay: assert property (p_shed_delay) else $error("phase drop before delay");
  property p_shed_range;
    shed_count <= 3'h4;
  endproperty
  a_shed_range: assert property (p_shed_range) else $error("shed count above four");
endmodule : phmcr_regs_sva
bind phmcr_regs phmcr_regs_sva u_sva (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .power_saving_input, .zone_level_first, .zone_level_second, .zone_active_mask,
  .load_line, .switching_frequency_select, .softstart_from_reg, .per_phase_current_limit,
  .shed_count, .thermal_shutdown_enable, .fault_latched_off, .fault_hiccup);
`default_nettype wire

// *** tb/phmcr_regs_tb.sv ***
// Self-checking bench for the phase management registers
`timescale 1ns/1ps
`default_nettype none
module phmcr_regs_tb;
  logic clk, reset_n, power_on_sense, stage_temp_fault, thermal_shutdown_fault;
  logic [1:0] power_saving_input, load_line;
  logic [7:0] phase_enabled, output_current_reading, sense_voltage_monitor, stage_temp_monitor;
  logic [2:0] zone_pin_first, zone_pin_second, zone_level_first, zone_level_second, shed_count;
  logic [31:0] shed_pin_value;
  logic [3:0] shed_pin_over_2v;
  logic [4:0] zone_active_mask;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, switching_frequency_select, softstart_from_reg, per_phase_current_limit;
  logic thermal_shutdown_enable, fault_latched_off, fault_hiccup;
  logic [7:0] exp_q[$];
  logic [7:0] ra[10] = '{8'h34, 8'h36, 8'h39, 8'h3a, 8'h3b, 8'h44, 8'h45, 8'h46, 8'h4b, 8'h50};
  logic [7:0] rv[10] = '{8'h1f, 8'h00, 8'h03, 8'hff, 8'hff, 8'h00, 8'h14, 8'h00, 8'h00, 8'h00};
  int bad_count = 0;
  int comparisons = 0;
  int hic_n = 0;
  phmcr_host host_u (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  phmcr_regs dut_u (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .power_saving_input, .phase_enabled, .power_on_sense, .zone_pin_first, .zone_pin_second,
    .shed_pin_value, .shed_pin_over_2v, .output_current_reading, .sense_voltage_monitor,
    .stage_temp_monitor, .stage_temp_fault, .thermal_shutdown_fault, .zone_level_first,
    .zone_level_second, .zone_active_mask, .load_line, .switching_frequency_select,
    .softstart_from_reg, .per_phase_current_limit, .shed_count, .thermal_shutdown_enable,
    .fault_latched_off, .fault_hiccup);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(string what, logic [7:0] seen, logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    host_u.rd(a);
  endtask : rd
  // Read data is taken one edge after the strobe, oldest note first
  initial begin
    forever begin
      @(posedge clk);
      if (reg_rd === 1'b1) begin
        #2;
        check("reg_rdata", reg_rdata, exp_q.pop_front());
      end
    end
  end
  always @(posedge clk) begin
    if (fault_hiccup === 1'b1) hic_n++;
  end
  initial begin
    #250000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    {power_on_sense, stage_temp_fault, thermal_shutdown_fault} = 3'h0;
    power_saving_input = phmcr_pkg::PSI_MID;
    phase_enabled = 8'($urandom(69041));
    {output_current_reading, sense_voltage_monitor, stage_temp_monitor} = 24'h000000;
    {zone_pin_first, zone_pin_second, shed_pin_value, shed_pin_over_2v} = 42'h0;
    cyc(2);
    reset_n = 1'b1;
    check("load_line", {6'h00, load_line}, 8'h03);
    foreach (ra[i]) rd(ra[i], rv[i]);
    for (int i = 0; i < 3; i++) begin
      power_saving_input = 2'(i);
      cyc(4);
      rd(phmcr_pkg::ADDR_POWER_SAVE_PIN_STATUS, 8'(i));
    end
    phase_enabled = 8'($urandom);
    sense_voltage_monitor = 8'($urandom);
    stage_temp_monitor = 8'($urandom);
    cyc(4);
    rd(phmcr_pkg::ADDR_PHASE_STATUS, phase_enabled);
    rd(phmcr_pkg::ADDR_SENSE_VOLT, sense_voltage_monitor);
    rd(phmcr_pkg::ADDR_STAGE_TEMP, stage_temp_monitor);
    host_u.wr(phmcr_pkg::ADDR_ZONE_ENABLE, 8'hea);
    rd(phmcr_pkg::ADDR_ZONE_ENABLE, 8'h0a);
    power_saving_input = phmcr_pkg::PSI_LOW;
    cyc(5);
    check("zone_active_mask", {3'h0, zone_active_mask}, 8'h0a);
    power_saving_input = phmcr_pkg::PSI_MID;
    cyc(5);
    check("zone_active_mask", {3'h0, zone_active_mask}, 8'h1f);
    {zone_pin_first, zone_pin_second} = 6'h10;
    {shed_pin_value, shed_pin_over_2v} = {32'h10203040, 4'he};
    power_on_sense = 1'b1;
    cyc(1);
    power_on_sense = 1'b0;
    cyc(3);
    rd(phmcr_pkg::ADDR_ZONE_STATUS, 8'h10);
    rd(phmcr_pkg::ADDR_SHED_STS1, 8'h40);
    rd(8'h3d, 8'hff);
    check("zone_level_first", {5'h00, zone_level_first}, 8'h02);
    host_u.wr(phmcr_pkg::ADDR_ZONE_CONFIG, 8'h0c);
    host_u.wr(phmcr_pkg::ADDR_ZONE_CONFIG, 8'h3f);
    rd(phmcr_pkg::ADDR_ZONE_CONFIG, 8'h0c);
    host_u.wr(phmcr_pkg::ADDR_LATCH_A, 8'h02);
    cyc(3);
    check("zone_level_first", {5'h00, zone_level_first}, 8'h02);
    host_u.wr(phmcr_pkg::ADDR_LATCH_B, 8'h02);
    cyc(3);
    check("zone_levels", {2'h0, zone_level_first, zone_level_second}, 8'h0b);
    host_u.wr(phmcr_pkg::ADDR_LATCH_A, 8'hff);
    rd(phmcr_pkg::ADDR_LATCH_A, 8'h2f);
    check("freq_mode", {7'h00, switching_frequency_select}, 8'h00);
    host_u.wr(phmcr_pkg::ADDR_LATCH_B, 8'h2f);
    cyc(2);
    check("mode_bits", {5'h00, switching_frequency_select, softstart_from_reg,
      per_phase_current_limit}, 8'h07);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(phmcr_pkg::ADDR_LOAD_LINE, 8'hfc | 8'(i));
      cyc(1);
      check("load_line", {6'h00, load_line}, 8'(i));
      rd(phmcr_pkg::ADDR_LOAD_LINE, 8'(i));
    end
    host_u.wr(phmcr_pkg::ADDR_SHED_CFG1, 8'h40);
    host_u.wr(phmcr_pkg::ADDR_SHED_HYST, 8'h04);
    host_u.wr(phmcr_pkg::ADDR_SHED_DELAY, 8'h01);
    output_current_reading = 8'hff;
    cyc(6);
    check("shed_count", {5'h00, shed_count}, 8'h01);
    output_current_reading = 8'h3c;
    cyc(1300);
    check("shed_count", {5'h00, shed_count}, 8'h01);
    output_current_reading = 8'h3b;
    cyc(1100);
    check("shed_count", {5'h00, shed_count}, 8'h01);
    cyc(200);
    check("shed_count", {5'h00, shed_count}, 8'h00);
    thermal_shutdown_fault = 1'b1;
    cyc(8);
    check("fault_state", {fault_latched_off, 7'(hic_n)}, 8'h00);
    thermal_shutdown_fault = 1'b0;
    host_u.wr(phmcr_pkg::ADDR_TEMP_RESP, 8'h01);
    host_u.wr(phmcr_pkg::ADDR_TSD_CONFIG, 8'h03);
    cyc(1);
    check("tsd_enable", {7'h00, thermal_shutdown_enable}, 8'h01);
    stage_temp_fault = 1'b1;
    cyc(8);
    check("hiccups", 8'(hic_n), 8'h01);
    thermal_shutdown_fault = 1'b1;
    cyc(8);
    check("hiccups", {fault_latched_off, 7'(hic_n)}, 8'h02);
    {stage_temp_fault, thermal_shutdown_fault} = 2'h0;
    host_u.wr(phmcr_pkg::ADDR_TEMP_RESP, 8'h00);
    cyc(4);
    stage_temp_fault = 1'b1;
    cyc(8);
    check("latched_off", {fault_latched_off, 7'(hic_n)}, 8'h82);
    cyc(10);
    report_and_stop();
  end
endmodule : phmcr_regs_tb
`default_nettype wire
